// ==== verilog/bla_unit.sv ====
`timescale 1ns/1ps
// How it works
// - separate memory and 64K I/O spaces, flagged
// - data bus is four independent byte lanes
// - doublewords start at multiples of four
// - drive upper 30 bits; low two pick lanes
// - 32, 24, 16 or 8 bits per cycle
// - operand inside one doubleword takes one cycle
// - boundary-crossing word or doubleword splits in two
// - word at offset 3: lane 0 next, lane 3
// - misaligned doubleword: next low lanes, then upper
// - reassemble split bytes into operand order
// - never non-contiguous lane strobes
// - three-byte cycle only within split doubleword
// - pipelining presents next address before cycle ends
// - first cycle after idle never pipelined
// - pipelined access three internal clocks, else two
// - wait states while transfer-done sampled high
// - next-address request sampled in phase 2
// - internal clock is half the input clock
module bla_unit (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire bla_pkg::bla_req_t req,
  output logic req_ready_ff,
  output logic rsp_valid_ff,
  output logic [31:0] rsp_data_ff,
  input wire logic rsp_ready,
  output logic internal_clock_ff,
  output logic [29:0] dword_address_ff,
  output logic [3:0] byte_lane_strobe_n_ff,
  output logic address_strobe_n_ff,
  output logic memory_space_ff,
  output logic write_cycle_ff,
  output logic [31:0] data_lines_out_ff,
  output logic data_lines_oe_ff,
  input wire logic [31:0] data_lines_in,
  input wire logic transfer_done_n,
  input wire logic next_address_request_n
);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [1:0] done_sync_ff;
  logic [1:0] na_sync_ff;
  logic [31:0] din_meta_ff;
  logic [31:0] din_ff;
  logic phase_ff;
  bla_pkg::bla_req_t op_ff;
  logic op_v_ff;
  logic half_ff;
  bla_pkg::bla_state_t st_ff;
  bla_pkg::bla_state_t nxt_st;
  bla_pkg::bla_cyc_t cur_ff;
  bla_pkg::bla_cyc_t nxt_ff;
  bla_pkg::bla_cyc_t issue_c;
  logic nxt_v_ff;
  logic piped_ff;
  logic na_held_ff;
  logic [31:0] asm_hi_ff;
  logic [1:0] occ_ff;
  logic [1:0] nxt_occ;
  logic nxt_op_v;
  logic slot1_v_ff;
  logic [31:0] slot1_d_ff;
  logic v0_a;
  logic v1_a;
  logic [31:0] d0_a;
  logic [31:0] d1_a;
  logic nxt_v0;
  logic nxt_v1;
  logic [31:0] nxt_d0;
  logic [31:0] nxt_d1;

  // reset is released through two flops so every register leaves reset together
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) rst_sync_ff <= 2'h0;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // pin inputs pass two flops; only the second stage is read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_sync_ff <= bla_pkg::SYNC_IDLE;
      na_sync_ff <= bla_pkg::SYNC_IDLE;
      din_meta_ff <= 32'h0;
      din_ff <= 32'h0;
    end else begin
      done_sync_ff <= {done_sync_ff[0], transfer_done_n};
      na_sync_ff <= {na_sync_ff[0], next_address_request_n};
      din_meta_ff <= data_lines_in;
      din_ff <= din_meta_ff;
    end
  end

  // phase_ff high marks phase 2, the last input-clock of an internal cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) phase_ff <= 1'b0;
    else phase_ff <= ~phase_ff;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) internal_clock_ff <= 1'b0;
    else internal_clock_ff <= phase_ff;
  end

  wire tick = phase_ff;
  wire in_second = (st_ff == bla_pkg::BLA_SECOND);
  wire done = tick & in_second & ~done_sync_ff[1];
  // the next address may go out from the second state, or from the first
  // state of a cycle whose own address was already pipelined
  wire na_window = in_second | ((st_ff == bla_pkg::BLA_FIRST) & piped_ff);
  wire na_hit = tick & ~na_sync_ff[1] & na_window;
  wire na_on = na_hit | (tick & na_held_ff & na_window);
  wire pipe_issue = na_on & op_v_ff & ~nxt_v_ff & ~done;
  // after idle only the plain path issues, so that cycle is never pipelined
  wire new_issue = tick & op_v_ff & ~nxt_v_ff & ((st_ff == bla_pkg::BLA_IDLE) | done);
  wire issue = pipe_issue | new_issue;
  wire promote = done & nxt_v_ff;
  wire cur_load = new_issue | promote;
  wire to_idle = done & ~nxt_v_ff & ~new_issue;
  wire accept = req_valid & req_ready_ff;
  wire pop = rsp_valid_ff & rsp_ready;

  // a request seen while nothing waits is held for the rest of the cycle, so
  // an operand that turns up later still goes out early; the end of the
  // cycle clears it even when a request arrives on that edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) na_held_ff <= 1'b0;
    else if (done | cur_load) na_held_ff <= 1'b0;
    else if (na_hit) na_held_ff <= 1'b1;
  end

  // operand decode
  wire [1:0] off = op_ff.addr[1:0];
  wire [7:0] lane8 = bla_pkg::lane_map(off, op_ff.size);
  wire split = |lane8[7:4];
  wire first_half = split & ~half_ff;
  wire [63:0] wd_wide = {32'h0, op_ff.wdata} << {off, 3'h0};
  wire [29:0] io_dw = {16'h0, op_ff.addr[bla_pkg::IO_ADDR_W-1:2]};
  wire [29:0] dw_base = op_ff.io ? io_dw : op_ff.addr[31:2];
  wire [29:0] dw_next = dw_base + 30'h1;

  // split order: the following doubleword with the low lanes first, then
  // this doubleword with the upper lanes; a 3-byte part never stands alone
  always_comb begin
    issue_c.dw = first_half ? dw_next : dw_base;
    issue_c.lanes = first_half ? lane8[7:4] : lane8[3:0];
    issue_c.write = op_ff.write;
    issue_c.io = op_ff.io;
    issue_c.last = ~first_half;
    issue_c.hi = first_half;
    issue_c.off = off;
    issue_c.size = op_ff.size;
    issue_c.wdata = first_half ? wd_wide[63:32] : wd_wide[31:0];
  end

  // reassembly: upper doubleword bytes were caught first
  wire [63:0] joined = {asm_hi_ff, din_ff};
  wire [63:0] shifted = joined >> {cur_ff.off, 3'h0};
  wire [31:0] rdata = shifted[31:0] & bla_pkg::size_mask(cur_ff.size);
  wire push = done & cur_ff.last & ~cur_ff.write;

  // operand slot
  assign nxt_op_v = (op_v_ff & ~(issue & ~first_half)) | accept;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op_v_ff <= 1'b0;
      half_ff <= 1'b0;
      op_ff <= '0;
    end else begin
      op_v_ff <= nxt_op_v;
      if (issue) half_ff <= first_half;
      if (accept) op_ff <= req;
    end
  end

  // bus state machine
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      bla_pkg::BLA_IDLE: begin
        if (new_issue) nxt_st = bla_pkg::BLA_FIRST;
      end
      bla_pkg::BLA_FIRST: begin
        if (tick) nxt_st = bla_pkg::BLA_SECOND;
      end
      bla_pkg::BLA_SECOND: begin
        if (cur_load) nxt_st = bla_pkg::BLA_FIRST;
        else if (done) nxt_st = bla_pkg::BLA_IDLE;
      end
      default: nxt_st = bla_pkg::BLA_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) st_ff <= bla_pkg::BLA_IDLE;
    else st_ff <= nxt_st;
  end

  // a promoted cycle had its address out a whole internal clock early,
  // which stretches address-to-data time from two clocks to three
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) piped_ff <= 1'b0;
    else if (tick) piped_ff <= promote;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '0;
      nxt_ff <= '0;
      nxt_v_ff <= 1'b0;
    end else begin
      if (new_issue) cur_ff <= issue_c;
      else if (promote) cur_ff <= nxt_ff;
      if (pipe_issue) nxt_ff <= issue_c;
      if (pipe_issue) nxt_v_ff <= 1'b1;
      else if (promote) nxt_v_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) asm_hi_ff <= 32'h0;
    else if (done & cur_ff.hi) asm_hi_ff <= din_ff;
  end

  // address side pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dword_address_ff <= 30'h0;
      byte_lane_strobe_n_ff <= bla_pkg::LANES_IDLE_N;
      address_strobe_n_ff <= 1'b1;
      memory_space_ff <= 1'b1;
      write_cycle_ff <= 1'b0;
    end else if (issue) begin
      dword_address_ff <= issue_c.dw;
      byte_lane_strobe_n_ff <= ~issue_c.lanes;
      address_strobe_n_ff <= 1'b0;
      memory_space_ff <= ~issue_c.io;
      write_cycle_ff <= issue_c.write;
    end else if (tick) begin
      address_strobe_n_ff <= 1'b1;
      if (to_idle) byte_lane_strobe_n_ff <= bla_pkg::LANES_IDLE_N;
    end
  end

  // write data follows the cycle that owns the data lanes, not the address
  wire [31:0] load_wdata = new_issue ? issue_c.wdata : nxt_ff.wdata;
  wire load_write = new_issue ? issue_c.write : nxt_ff.write;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_lines_out_ff <= 32'h0;
      data_lines_oe_ff <= 1'b0;
    end else if (cur_load) begin
      data_lines_out_ff <= load_wdata;
      data_lines_oe_ff <= load_write;
    end else if (to_idle) begin
      data_lines_oe_ff <= 1'b0;
    end
  end

  // occupancy counts reads accepted but not yet taken by the receiver,
  // so the two-entry buffer can never overflow
  assign nxt_occ = occ_ff + {1'b0, accept & ~req.write} - {1'b0, pop};
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      occ_ff <= 2'h0;
      req_ready_ff <= 1'b0;
    end else begin
      occ_ff <= nxt_occ;
      req_ready_ff <= ~nxt_op_v & (nxt_occ < 2'(bla_pkg::FIFO_DEPTH));
    end
  end

  // two-entry response buffer; slot 0 is the output register
  assign v0_a = pop ? slot1_v_ff : rsp_valid_ff;
  assign d0_a = pop ? slot1_d_ff : rsp_data_ff;
  assign v1_a = pop ? 1'b0 : slot1_v_ff;
  assign d1_a = slot1_d_ff;
  assign nxt_v0 = v0_a | push;
  assign nxt_d0 = v0_a ? d0_a : rdata;
  assign nxt_v1 = v1_a | (push & v0_a);
  assign nxt_d1 = (push & v0_a) ? rdata : d1_a;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 32'h0;
      slot1_v_ff <= 1'b0;
      slot1_d_ff <= 32'h0;
    end else begin
      rsp_valid_ff <= nxt_v0;
      rsp_data_ff <= nxt_d0;
      slot1_v_ff <= nxt_v1;
      slot1_d_ff <= nxt_d1;
    end
  end

endmodule : bla_unit

// ==== verilog/bla_pkg.sv ====
package bla_pkg;

  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int DW_ADDR_W = 30;
  localparam int IO_ADDR_W = 16;
  localparam int FIFO_DEPTH = 2;

  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;

  localparam logic [3:0] LANES_IDLE_N = 4'hf;
  localparam logic [1:0] SYNC_IDLE = 2'h3;

  typedef enum logic [1:0] {
    BLA_IDLE = 2'h0,
    BLA_FIRST = 2'h1,
    BLA_SECOND = 2'h3
  } bla_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0] size;
    logic write;
    logic io;
    logic [31:0] wdata;
  } bla_req_t;

  typedef struct packed {
    logic [29:0] dw;
    logic [3:0] lanes;
    logic write;
    logic io;
    logic last;
    logic hi;
    logic [1:0] off;
    logic [1:0] size;
    logic [31:0] wdata;
  } bla_cyc_t;

  // lanes touched by an operand across two doublewords; [7:4] is the next one
  function automatic logic [7:0] lane_map(input logic [1:0] off, input logic [1:0] size);
    logic [7:0] m;
    m = 8'h0f;
    if (size == SIZE_BYTE) m = 8'h01;
    else if (size == SIZE_WORD) m = 8'h03;
    return m << off;
  endfunction : lane_map

  function automatic logic [31:0] size_mask(input logic [1:0] size);
    logic [31:0] m;
    m = 32'hffffffff;
    if (size == SIZE_BYTE) m = 32'h000000ff;
    else if (size == SIZE_WORD) m = 32'h0000ffff;
    return m;
  endfunction : size_mask

endpackage : bla_pkg

// ==== tb/bla_chk_assertions.sv ====
`timescale 1ns/1ps
module bla_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire logic req_ready_ff,
  input wire logic internal_clock_ff,
  input wire logic [3:0] byte_lane_strobe_n_ff,
  input wire logic address_strobe_n_ff,
  input wire logic write_cycle_ff,
  input wire logic data_lines_oe_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_low2;
    !address_strobe_n_ff ##1 address_strobe_n_ff;
  endsequence
  sequence s_tog;
    $fell(internal_clock_ff) ##1 $rose(internal_clock_ff);
  endsequence
  a_lanes_contig: assert property (!((~byte_lane_strobe_n_ff) inside {4'h5, 4'h9, 4'ha, 4'hb, 4'hd}))
    else $error("gap in lane set");
  a_clock_half: assert property ($rose(internal_clock_ff) |=> s_tog)
    else $error("internal clock not half rate");
  a_ads_two: assert property ($fell(address_strobe_n_ff) |=> s_low2)
    else $error("address strobe not two clocks");
  a_ads_lanes: assert property (!address_strobe_n_ff |-> byte_lane_strobe_n_ff != 4'hf)
    else $error("cycle with no lanes");
  a_lanes_hold: assert property ($fell(address_strobe_n_ff) |=> $stable(byte_lane_strobe_n_ff))
    else $error("lanes moved in first state");
  a_first_unpiped: assert property ($past(byte_lane_strobe_n_ff) == 4'hf &&
    byte_lane_strobe_n_ff != 4'hf |-> $fell(address_strobe_n_ff))
    else $error("cycle after idle without strobe");
  a_new_addr: assert property ($changed(byte_lane_strobe_n_ff) && byte_lane_strobe_n_ff != 4'hf
    |-> !address_strobe_n_ff)
    else $error("lanes changed without strobe");
  a_ready_drop: assert property (req_valid && req_ready_ff |=> !req_ready_ff)
    else $error("slot still free after take");
  a_oe_write: assert property ($rose(data_lines_oe_ff) |-> write_cycle_ff)
    else $error("data lines driven for a read");
  a_oe_idle: assert property (byte_lane_strobe_n_ff == 4'hf |-> !data_lines_oe_ff)
    else $error("data lines driven while idle");
endmodule : bla_chk

// ==== tb/bla_mem.sv ====
`timescale 1ns/1ps
module bla_mem (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic pipe,
  input wire logic [1:0] waits,
  input wire logic [29:0] dw,
  input wire logic [3:0] stb_n,
  input wire logic ads_n,
  input wire logic space,
  input wire logic write,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata = 32'h0,
  output logic done_n = 1'b1,
  output logic na_n = 1'b1
);
  logic [7:0] mem [logic [32:0]];
  logic [35:0] q [$];
  logic [32:0] k;
  logic prev = 1'b1;
  int cnt = 0;
  int tw = 0;
  always @(posedge clock) begin
    prev <= ads_n;
    na_n <= !pipe;
    if (!rst_b) begin
      q.delete();
      cnt = 0;
      done_n <= 1'b1;
    end else begin
      if (prev && !ads_n) q.push_back({write, space, dw, stb_n});
      if (q.size() > 0) begin
        // slack so write data of a promoted cycle has landed
        if (cnt == 0) tw = 4 + 2 * waits;
        cnt++;
        if (cnt == tw) begin
          done_n <= 1'b0;
          for (int l = 0; l < 4; l++) begin
            k = {q[0][34:4], 2'(l)};
            if (q[0][35] && !q[0][l]) mem[k] = wdata[8*l +: 8];
            rdata[8*l +: 8] <= mem.exists(k) ? mem[k] : 8'h00;
          end
        end
        if (cnt == tw + 2) begin
          done_n <= 1'b1;
          rdata <= ~rdata;
          void'(q.pop_front());
          cnt = 0;
        end
      end
    end
  end
endmodule : bla_mem

// ==== tb/tb_byte_lane_alignment_unit.sv ====
`timescale 1ns/1ps
module tb_byte_lane_alignment_unit;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic rsp_ready = 1'b1;
  logic pipe = 1'b0;
  logic ok;
  logic pa = 1'b1;
  logic [1:0] waits = 2'h0;
  bla_pkg::bla_req_t req = '0;
  bla_pkg::bla_req_t r;
  logic done_n, na_n, ads_n, rv, rdy, sp, wr;
  logic [29:0] dw;
  logic [3:0] stb;
  logic [31:0] din, dout, rd;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed;
  logic [7:0] bm [logic [32:0]];
  logic [35:0] ec [$];
  logic [31:0] er [$];
  always #2.5 clock = !clock;
  bla_unit i_dut (.clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready_ff(rdy), .rsp_valid_ff(rv), .rsp_data_ff(rd), .rsp_ready(rsp_ready),
    .internal_clock_ff(), .dword_address_ff(dw), .byte_lane_strobe_n_ff(stb),
    .address_strobe_n_ff(ads_n), .memory_space_ff(sp), .write_cycle_ff(wr),
    .data_lines_out_ff(dout), .data_lines_oe_ff(), .data_lines_in(din),
    .transfer_done_n(done_n), .next_address_request_n(na_n));
  bla_mem i_mem (.clock(clock), .rst_b(rst_b), .pipe(pipe), .waits(waits), .dw(dw),
    .stb_n(stb), .ads_n(ads_n), .space(sp), .write(wr), .wdata(dout), .rdata(din),
    .done_n(done_n), .na_n(na_n));
  task automatic chk(input string what, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      conclude();
    end else begin
      if (pa && !ads_n) chk("bus cycle", ec.pop_front(), {wr, sp, dw, stb});
      pa = ads_n;
      if (rv === 1'b1 && rsp_ready === 1'b1) chk("read data", 36'(er.pop_front()), 36'(rd));
    end
  end
  task automatic send(input bla_pkg::bla_req_t q, input int lim);
    int n;
    logic [7:0] mk;
    logic [31:0] e;
    logic [29:0] d;
    @(posedge clock);
    req_valid <= 1'b1;
    req <= q;
    pipe <= 1'($urandom);
    waits <= 2'($urandom % 3);
    ok = 1'b0;
    for (n = 0; n < lim && !ok; n++) begin
      @(posedge clock);
      ok = (rdy === 1'b1);
    end
    req_valid <= 1'b0;
    if (!ok) return;
    n = 1 << q.size;
    mk = 8'((1 << n) - 1) << q.addr[1:0];
    d = q.io ? {16'h0, q.addr[15:2]} : q.addr[31:2];
    if (mk[7:4] != 4'h0) ec.push_back({q.write, !q.io, d + 30'h1, ~mk[7:4]});
    ec.push_back({q.write, !q.io, d, ~mk[3:0]});
    e = '0;
    for (int m = 0; m < n; m++) begin
      if (q.write) bm[{q.io, q.addr + 32'(m)}] = q.wdata[8*m +: 8];
      e[8*m +: 8] = bm.exists({q.io, q.addr + 32'(m)}) ? bm[{q.io, q.addr + 32'(m)}] : 8'h0;
    end
    if (!q.write) er.push_back(e);
  endtask : send
  function automatic bla_pkg::bla_req_t mk_req(input int io, input int sz, input int off);
    bla_pkg::bla_req_t q;
    // i/o kept clear of the top of its space so the next doubleword never wraps
    q.addr = io ? ($urandom & 32'h7ff0) : $urandom;
    q.addr[1:0] = 2'(off);
    q.size = 2'(sz);
    q.write = 1'b1;
    q.io = 1'(io);
    q.wdata = $urandom;
    return q;
  endfunction : mk_req
  initial begin
    seed = $urandom(69);
    repeat (4) @(posedge clock);
    chk("idle outputs", 36'h3f, {30'h0, stb, ads_n, sp});
    rst_b <= 1'b1;
    for (int io = 0; io < 2; io++)
      for (int k = 0; k < 12; k++) begin
        r = mk_req(io, k / 4, k % 4);
        send(r, 200);
        chk("taken", 36'h1, 36'(ok));
        r.write = 1'b0;
        send(r, 200);
      end
    while (ec.size() > 0 || er.size() > 0) @(posedge clock);
    $display("test aligned and split transfers done");
    rsp_ready <= 1'b0;
    ok = 1'b1;
    for (int k = 0; k < 6 && ok; k++) begin
      r = mk_req(0, 2, k % 4);
      r.write = 1'b0;
      send(r, 40);
    end
    chk("full buffer", 36'h0, 36'(ok));
    while (er.size() > 0) begin
      @(posedge clock);
      rsp_ready <= 1'($urandom);
    end
    rsp_ready <= 1'b1;
    while (ec.size() > 0) @(posedge clock);
    $display("test stalled receiver done");
    conclude();
  end
endmodule : tb_byte_lane_alignment_unit
bind bla_unit bla_chk i_chk (.clock(clock), .rst_b(rst_b), .req_valid(req_valid),
  .req_ready_ff(req_ready_ff), .internal_clock_ff(internal_clock_ff),
  .byte_lane_strobe_n_ff(byte_lane_strobe_n_ff), .address_strobe_n_ff(address_strobe_n_ff),
  .write_cycle_ff(write_cycle_ff), .data_lines_oe_ff(data_lines_oe_ff));
